/* src/power_clock_pkg.sv */
// constants, register map and clock steps of the power and clock manager
package power_clock_pkg;

    // bus geometry: byte address is four times the register index
    localparam int          ADDR_W     = 10;
    localparam int          DATA_W     = 8;
    localparam logic [7:0]  IDX_POWER_CONTROL   = 8'h87;
    localparam logic [7:0]  IDX_CLK    = 8'ha3;
    localparam logic [7:0]  IDX_PD     = 8'ha4;
    localparam logic [7:0]  IDX_WU     = 8'ha5;
    localparam logic [7:0]  IDX_CAUSE  = 8'hb1;

    // reset values and writable masks
    localparam logic [7:0]  CLK_RST    = 8'h80;
    localparam logic [7:0]  CLK_MASK   = 8'hf3;
    localparam logic [7:0]  POWER_CONTROL_RST   = 8'h00;
    localparam logic [7:0]  POWER_CONTROL_MASK  = 8'hfc;
    localparam logic [7:0]  WU_RST     = 8'h00;
    localparam logic [7:0]  ZERO8      = 8'h00;

    // field positions
    localparam int          PLL_BIT    = 7;
    localparam int          LF_BIT     = 3;
    localparam int          PMW_BIT    = 4;
    localparam int          SMOD_BIT   = 7;
    localparam int          STOP_BIT   = 1;
    localparam int          IDLE_BIT   = 0;
    localparam int          WU_LSB [4] = '{6, 4, 2, 0};
    localparam int          IEN_BIT[4] = '{1, 5, 4, 3};

    // wakeup configuration codes
    localparam logic [1:0]  CFG_IF_EN  = 2'b00;
    localparam logic [1:0]  CFG_ALWAYS = 2'b10;
    localparam logic [1:0]  CFG_IGNORE = 2'b11;

    // synchroniser reset: pin reset high, supply good, no power fail
    localparam logic [2:0]  SYNC_RST   = 3'b110;

    // clock rates and phase-accumulator steps
    localparam int          CLK_PERIOD_NS = 40;
    localparam logic [63:0] CLK_HZ     = 64'd25_000_000;
    localparam int          ACC_W      = 24;
    localparam logic [23:0] STEP_16M   = 24'((64'd16_000_000 << ACC_W) / CLK_HZ);
    localparam logic [23:0] STEP_12M   = 24'((64'd12_000_000 << ACC_W) / CLK_HZ);
    localparam logic [23:0] STEP_8M    = 24'((64'd8_000_000 << ACC_W) / CLK_HZ);
    localparam logic [23:0] STEP_4M    = 24'((64'd4_000_000 << ACC_W) / CLK_HZ);
    localparam logic [23:0] STEP_1M6   = 24'((64'd1_600_000 << ACC_W) / CLK_HZ);
    localparam logic [23:0] STEP_320K  = 24'((64'd320_000 << ACC_W) / CLK_HZ);
    localparam logic [23:0] STEP_64K   = 24'((64'd64_000 << ACC_W) / CLK_HZ);
    localparam logic [63:0] LF_HZ      = 64'd32_000;
    localparam logic [15:0] LF_HALF    = 16'(CLK_HZ / (64'd2 * LF_HZ));
    localparam logic [15:0] LF_ONE     = 16'h0001;

endpackage : power_clock_pkg

/* src/power_clock_manager.sv */
// power and clock manager: registers, clock enables, standby, wakeup, resets
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module power_clock_manager #(
    parameter int HOLD_W            = 8,
    parameter int RESET_HOLD_CYCLES = 16
) (
    // clock and reset
    input  wire logic                                CLOCK_I,
    input  wire logic                                RST_I,
    // avalon-mm slave
    input  wire logic [power_clock_pkg::ADDR_W-1:0]  AVS_ADDRESS_I,
    input  wire logic                                AVS_READ_I,
    input  wire logic                                AVS_WRITE_I,
    input  wire logic [power_clock_pkg::DATA_W-1:0]  AVS_WRITEDATA_I,
    output logic      [power_clock_pkg::DATA_W-1:0]  AVS_READDATA_O,
    output logic                                     AVS_WAITREQUEST_O,
    // reset sources and supply supervisor
    input  wire logic                                RESET_PIN_N_I,
    input  wire logic                                WATCHDOG_I,
    input  wire logic                                SUPPLY_GOOD_I,
    input  wire logic                                POWER_FAIL_I,
    output logic                                     SYS_RESET_O,
    // usb state and wakeup sources
    input  wire logic                                USB_SUSPENDED_I,
    input  wire logic                                RADIO_IRQ_I,
    input  wire logic                                INTERNAL_WAKEUP_EVENT_I,
    input  wire logic                                USB_INTERRUPT_I,
    input  wire logic                                USB_BUS_WAKEUP_I,
    input  wire logic [7:0]                          INTERRUPT_ENABLE_HIGH_I,
    output logic      [3:0]                          WAKE_FLAG_SET_O,
    // clock and power outputs
    output logic                                     PLL_ENABLE_O,
    output logic                                     MCU_CLOCK_EN_O,
    output logic                                     MCU_STANDBY_O,
    output logic                                     STOP_REQ_O,
    output logic                                     IDLE_REQ_O,
    output logic                                     PROG_WRITE_EN_O,
    output logic                                     BAUD_DOUBLE_O,
    // flash guard
    input  wire logic                                FLASH_WRITE_REQ_I,
    input  wire logic                                FLASH_ERASE_REQ_I,
    output logic                                     FLASH_WRITE_GO_O,
    output logic                                     FLASH_ERASE_GO_O
);
    import power_clock_pkg::*;

    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(RESET_HOLD_CYCLES);
    localparam logic [HOLD_W-1:0] HOLD_ONE  = HOLD_W'(1);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [2:0]        sync_a;
    logic [2:0]        sync_b;
    logic              wait_q;
    logic [7:0]        rdata;
    logic [7:0]        clk_ctl;
    logic [7:0]        power_control;
    logic [7:0]        wu_cfg;
    logic              cause;
    logic              standby;
    logic              pll_q;
    logic              clk_en;
    logic              stop_q;
    logic              idle_q;
    logic [3:0]        wake_flag;
    logic              sys_rst;
    logic [HOLD_W-1:0] hold_cnt;
    logic              fl_wr;
    logic              fl_er;
    logic [ACC_W-1:0]  acc;
    logic [ACC_W-1:0]  active_step;
    logic [15:0]       lf_cnt;
    logic              lf_level;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: only the second stage is read

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            sync_a <= SYNC_RST;
            sync_b <= SYNC_RST;
        end else begin
            sync_a <= {RESET_PIN_N_I, SUPPLY_GOOD_I, POWER_FAIL_I};
            sync_b <= sync_a;
        end
    end

    wire pin_n_s = sync_b[2];
    wire good_s  = sync_b[1];
    wire fail_s  = sync_b[0];

    ////////////////////////////////////////////////////////////////////////////
    // reset sequencer: every source loads the same hold count

    wire rst_req  = !pin_n_s || WATCHDOG_I || !good_s;
    wire hold_nz  = hold_cnt != '0;
    wire reg_rst  = RST_I || sys_rst;

    always_ff @(posedge CLOCK_I) begin
        if (RST_I || rst_req)
            hold_cnt <= HOLD_LOAD;
        else if (hold_nz)
            hold_cnt <= hold_cnt - HOLD_ONE;
    end

    // reset stays high while supply is low, then for the hold count
    always_ff @(posedge CLOCK_I) begin
        if (RST_I)
            sys_rst <= 1'b1;
        else
            sys_rst <= rst_req || hold_nz;
    end

    // cause is latched at the start of a sequence and survives it
    always_ff @(posedge CLOCK_I) begin
        if (RST_I)
            cause <= 1'b0;
        else if (rst_req && !sys_rst)
            cause <= WATCHDOG_I;
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus decode: one wait cycle, then the answer

    wire [7:0] idx    = AVS_ADDRESS_I[ADDR_W-1:2];
    wire       sel_pc = idx == IDX_POWER_CONTROL;
    wire       sel_ck = idx == IDX_CLK;
    wire       sel_pd = idx == IDX_PD;
    wire       sel_wu = idx == IDX_WU;
    wire       sel_ca = idx == IDX_CAUSE;
    wire       req    = AVS_READ_I || AVS_WRITE_I;
    wire       wr_ok  = AVS_WRITE_I && !wait_q;
    wire [7:0] wd     = AVS_WRITEDATA_I;

    // read views: reserved and write-only bits read zero
    wire [7:0] rd_pc  = power_control & POWER_CONTROL_MASK;
    wire [7:0] rd_ck  = clk_ctl & CLK_MASK;
    wire [7:0] rd_pd  = {4'h0, lf_level, 3'h0};
    wire [7:0] rd_ca  = {7'h00, cause};
    wire [7:0] rd_mux = sel_pc ? rd_pc :
                        sel_ck ? rd_ck :
                        sel_pd ? rd_pd :
                        sel_wu ? wu_cfg :
                        sel_ca ? rd_ca : ZERO8;

    always_ff @(posedge CLOCK_I) begin
        if (RST_I)
            wait_q <= 1'b1;
        else
            wait_q <= !(req && wait_q);
    end

    always_ff @(posedge CLOCK_I) begin
        if (RST_I)
            rdata <= ZERO8;
        else if (AVS_READ_I && wait_q)
            rdata <= rd_mux;
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers

    // pll bit only moves while usb is suspended
    wire [7:0] ck_wr = {USB_SUSPENDED_I ? wd[PLL_BIT] : clk_ctl[PLL_BIT],
                        wd[6:0]} & CLK_MASK;

    always_ff @(posedge CLOCK_I) begin
        if (reg_rst)
            clk_ctl <= CLK_RST;
        else if (wr_ok && sel_ck)
            clk_ctl <= ck_wr;
    end

    // flag bits store plainly; stop and idle bits are not kept
    always_ff @(posedge CLOCK_I) begin
        if (reg_rst)
            power_control <= POWER_CONTROL_RST;
        else if (wr_ok && sel_pc)
            power_control <= wd & POWER_CONTROL_MASK;
    end

    always_ff @(posedge CLOCK_I) begin
        if (reg_rst)
            wu_cfg <= WU_RST;
        else if (wr_ok && sel_wu)
            wu_cfg <= wd;
    end

    // stop and idle requests are one-cycle pulses
    always_ff @(posedge CLOCK_I) begin
        if (reg_rst) begin
            stop_q <= 1'b0;
            idle_q <= 1'b0;
        end else begin
            stop_q <= wr_ok && sel_pc && wd[STOP_BIT];
            idle_q <= wr_ok && sel_pc && wd[IDLE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wakeup qualification per source

    wire [3:0] wake_evt = {USB_BUS_WAKEUP_I, USB_INTERRUPT_I,
                           INTERNAL_WAKEUP_EVENT_I, RADIO_IRQ_I};
    wire [3:0] qual;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_wake
            wire [1:0] code = wu_cfg[WU_LSB[gi] +: 2];
            wire       en   = INTERRUPT_ENABLE_HIGH_I[IEN_BIT[gi]];
            // enable-gated, forced or ignored; reserved code never wakes
            assign qual[gi] = wake_evt[gi] &&
                ((code == CFG_IF_EN && en) ||
                 code == CFG_ALWAYS);
        end
    endgenerate

    wire wake_any  = |qual;
    wire pd_enter  = wr_ok && sel_pd && (wd[2:0] != 3'h0);

    // firmware is trusted to have cleared pending flags first
    // a wakeup in the same cycle as the standby write is lost; the write wins
    always_ff @(posedge CLOCK_I) begin
        if (reg_rst)
            standby <= 1'b0;
        else if (standby && wake_any)
            standby <= 1'b0;
        else if (pd_enter)
            standby <= 1'b1;
    end

    // request flags are set in standby only for qualified sources, so the enable gates them too
    always_ff @(posedge CLOCK_I) begin
        if (reg_rst)
            wake_flag <= 4'h0;
        else
            wake_flag <= standby ? qual : 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // mcu clock enable from a phase accumulator

    wire pll_on = clk_ctl[PLL_BIT] || !USB_SUSPENDED_I;

    logic [ACC_W-1:0] step_on;
    logic [ACC_W-1:0] step_off;

    // rate tables; reserved codes fall back to the fastest rate
    always_comb begin
        case (clk_ctl[6:4])
            3'h0:    step_on = STEP_16M;
            3'h1:    step_on = STEP_12M;
            3'h2:    step_on = STEP_8M;
            3'h3:    step_on = STEP_4M;
            3'h4:    step_on = STEP_1M6;
            default: step_on = STEP_16M;
        endcase
        case (clk_ctl[1:0])
            2'h0:    step_off = STEP_4M;
            2'h1:    step_off = STEP_1M6;
            2'h2:    step_off = STEP_320K;
            default: step_off = STEP_64K;
        endcase
    end

    wire [ACC_W-1:0] step_sel = pll_on ? step_on : step_off;
    wire [ACC_W:0]   acc_sum  = {1'b0, acc} + {1'b0, active_step};
    wire             carry    = acc_sum[ACC_W];

    // new rate is taken only on a pulse so no period is cut short
    always_ff @(posedge CLOCK_I) begin
        if (reg_rst) begin
            acc         <= '0;
            active_step <= STEP_16M;
        end else begin
            acc <= acc_sum[ACC_W-1:0];
            if (carry)
                active_step <= step_sel;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (reg_rst) begin
            clk_en <= 1'b0;
            pll_q  <= 1'b1;
        end else begin
            clk_en <= carry && !standby;
            pll_q  <= pll_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // low-frequency clock level, cleared only by RST_I and free running through system resets

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            lf_cnt   <= '0;
            lf_level <= 1'b0;
        end else if (lf_cnt == LF_HALF - LF_ONE) begin
            lf_cnt   <= '0;
            lf_level <= !lf_level;
        end else begin
            lf_cnt   <= lf_cnt + LF_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flash guard

    always_ff @(posedge CLOCK_I) begin
        if (reg_rst) begin
            fl_wr <= 1'b0;
            fl_er <= 1'b0;
        end else begin
            fl_wr <= FLASH_WRITE_REQ_I && !fail_s;
            fl_er <= FLASH_ERASE_REQ_I && !fail_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign AVS_READDATA_O    = rdata;
    assign AVS_WAITREQUEST_O = wait_q;
    assign SYS_RESET_O       = sys_rst;
    assign WAKE_FLAG_SET_O   = wake_flag;
    assign PLL_ENABLE_O      = pll_q;
    assign MCU_CLOCK_EN_O    = clk_en;
    assign MCU_STANDBY_O     = standby;
    assign STOP_REQ_O        = stop_q;
    assign IDLE_REQ_O        = idle_q;
    assign PROG_WRITE_EN_O   = power_control[PMW_BIT];
    assign BAUD_DOUBLE_O     = power_control[SMOD_BIT];
    assign FLASH_WRITE_GO_O  = fl_wr;
    assign FLASH_ERASE_GO_O  = fl_er;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);

    pll_force_a: assert property (!USB_SUSPENDED_I && !sys_rst |=> PLL_ENABLE_O)
        else $error("pll not forced on while usb active");

    pll_write_a: assert property (wr_ok && sel_ck && USB_SUSPENDED_I && !reg_rst
        |=> clk_ctl[PLL_BIT] == $past(wd[PLL_BIT]))
        else $error("pll bit write lost");

    standby_set_a: assert property (pd_enter && !wake_any && !reg_rst
        |=> MCU_STANDBY_O ##1 !MCU_CLOCK_EN_O)
        else $error("standby not entered");

    wake_resume_a: assert property (standby && wake_any && !reg_rst
        |=> !MCU_STANDBY_O && (WAKE_FLAG_SET_O == $past(qual)))
        else $error("wakeup did not resume clock");

    wake_flag_a: assert property (standby && qual[0] && !reg_rst
        |=> WAKE_FLAG_SET_O[0])
        else $error("wake flag not set");

    radio_ignore_a: assert property (wu_cfg[7:6] == CFG_IGNORE
        || (wu_cfg[7:6] == CFG_IF_EN && !INTERRUPT_ENABLE_HIGH_I[IEN_BIT[0]]) |-> !qual[0])
        else $error("radio wake not gated");

    cause_wd_a: assert property (WATCHDOG_I && !sys_rst |=> cause ##1 SYS_RESET_O)
        else $error("watchdog cause not recorded");

    brown_hold_a: assert property (!good_s |=> SYS_RESET_O [*2])
        else $error("reset released during brown-out");

    flash_block_a: assert property (fail_s |=> !FLASH_WRITE_GO_O && !FLASH_ERASE_GO_O)
        else $error("flash op passed during power fail");

    power_control_read_a: assert property (AVS_READ_I && sel_pc && !wait_q
        |-> AVS_READDATA_O[1:0] == 2'b00)
        else $error("stop or idle bit read back set");

    bus_answer_a: assert property (req && wait_q |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
        else $error("bus answer not one cycle");

    wake_cov: cover property (pd_enter ##[1:200] (standby && wake_any));
    wdog_cov: cover property (WATCHDOG_I && !sys_rst ##1 sys_rst);
    plloff_cov: cover property (USB_SUSPENDED_I && !pll_on ##1 clk_en);

endmodule : power_clock_manager

/* verification/mcu_core_model.sv */
// model of the mcu core side: request flags and clock enable counting
`timescale 1ns/100ps
module mcu_core_model (
    // clock and control
    input  wire logic        clk_i,
    input  wire logic        clear_i,
    // from the manager
    input  wire logic        clock_en_i,
    input  wire logic [3:0]  flag_set_i,
    // observed state
    output logic      [3:0]  request_flags_o,
    output logic      [15:0] clock_count_o
);
    // flags latch until firmware clears them, clock enables are counted
    always_ff @(posedge clk_i) begin
        if (clear_i) begin
            request_flags_o <= 4'h0;
            clock_count_o   <= 16'h0000;
        end else begin
            request_flags_o <= request_flags_o | flag_set_i;
            clock_count_o   <= clock_count_o + 16'(clock_en_i);
        end
    end
endmodule : mcu_core_model

/* verification/testbench.sv */
// self-checking bench for the power and clock manager
`timescale 1ns/100ps
module testbench;
    import power_clock_pkg::*;
    logic clk = 0, rst = 1, rd = 0, wr = 0, pin_n = 1, wdog = 0, sgood = 1, pfail = 0;
    logic usb_susp = 0, fw = 0, fe = 0, clr = 1;
    logic [ADDR_W-1:0] addr = '0;
    logic [7:0] wdata = 8'h00, ien = 8'h00, rdata, stop_n = 0, idle_n = 0;
    logic [3:0] ev = 4'h0, wflag, irqf;
    logic [15:0] cnt, note, expq[$];
    logic wreq, sysrst, pll, clken, stby, stopr, idler, pmw, baud, fwgo, fego;
    logic [31:0] seed = 32'h3f762be7;
    int n_errors = 0, comparisons = 0;
    int khz [10] = '{16000, 12000, 8000, 4000, 1600, 4000, 1600, 320, 64, 16000};

    power_clock_manager i_power_clock_manager (
        .CLOCK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(wreq), .RESET_PIN_N_I(pin_n), .WATCHDOG_I(wdog),
        .SUPPLY_GOOD_I(sgood), .POWER_FAIL_I(pfail), .SYS_RESET_O(sysrst),
        .USB_SUSPENDED_I(usb_susp), .RADIO_IRQ_I(ev[0]), .INTERNAL_WAKEUP_EVENT_I(ev[1]),
        .USB_INTERRUPT_I(ev[2]), .USB_BUS_WAKEUP_I(ev[3]), .INTERRUPT_ENABLE_HIGH_I(ien),
        .WAKE_FLAG_SET_O(wflag), .PLL_ENABLE_O(pll), .MCU_CLOCK_EN_O(clken),
        .MCU_STANDBY_O(stby), .STOP_REQ_O(stopr), .IDLE_REQ_O(idler),
        .PROG_WRITE_EN_O(pmw), .BAUD_DOUBLE_O(baud), .FLASH_WRITE_REQ_I(fw),
        .FLASH_ERASE_REQ_I(fe), .FLASH_WRITE_GO_O(fwgo), .FLASH_ERASE_GO_O(fego));
    mcu_core_model i_mcu_core_model (.clk_i(clk), .clear_i(clr), .clock_en_i(clken),
        .flag_set_i(wflag), .request_flags_o(irqf), .clock_count_o(cnt));

    ////////////////////////////////////////////////////////////////
    // clock, pulse counters and read data monitor
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        stop_n <= stop_n + {7'h00, stopr === 1'b1};
        idle_n <= idle_n + {7'h00, idler === 1'b1};
        if (rd && wreq === 1'b0) begin
            if (expq.size() == 0) begin
                chk("read queue", 8'h00, 8'h01);
            end else begin
                note = expq.pop_front();
                chk("read data", note[7:0], rdata & note[15:8]);
            end
        end
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        final_report();
    end

    task automatic chk(input string what, input logic [7:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // one bus access held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] idx, d, m, e);
        int n = 0;
        @(posedge clk);
        addr <= {idx, 2'b00};
        wr <= w;
        rd <= !w;
        wdata <= d;
        if (!w) expq.push_back({m, e & m});
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        if (n >= 20) begin
            n_errors++;
            final_report();
        end
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic wait_sysrst;
        int n = 0;
        while (sysrst !== 1'b0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n >= 400) begin
            n_errors++;
            final_report();
        end
    endtask : wait_sysrst
    task automatic pulse_event(input int s);
        ev <= 4'h1 << s;
        @(posedge clk);
        ev <= 4'h0;
        cyc(3);
    endtask : pulse_event

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int k, c, s, code, ones, zeros;
        logic wake, inr;
        logic [7:0] d, cfg, s0, i0;
        logic [15:0] expc;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        clr <= 1'b0;
        wait_sysrst();
        bus(0, IDX_CLK, 0, 8'hff, 8'h80);
        bus(0, IDX_POWER_CONTROL, 0, 8'hff, 8'h00);
        bus(0, IDX_WU, 0, 8'hff, 8'h00);
        bus(0, IDX_CAUSE, 0, 8'hff, 8'h00);
        bus(0, 8'h10, 0, 8'hff, 8'h00);
        $display("test reset values done");
        for (k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            s0 = stop_n;
            i0 = idle_n;
            bus(1, IDX_POWER_CONTROL, seed[7:0], 0, 0);
            cyc(3);
            chk("stop pulses", {7'h0, seed[1]}, stop_n - s0);
            chk("idle pulses", {7'h0, seed[0]}, idle_n - i0);
            chk("program write", {7'h0, seed[4]}, {7'h0, pmw});
            chk("baud double", {7'h0, seed[7]}, {7'h0, baud});
            bus(0, IDX_POWER_CONTROL, 0, 8'hff, seed[7:0] & 8'hfc);
        end
        $display("test power control done");
        bus(1, IDX_CLK, 8'h03, 0, 0);
        bus(0, IDX_CLK, 0, 8'hff, 8'h83);
        chk("pll kept on", 8'h01, {7'h0, pll});
        usb_susp <= 1'b1;
        for (k = 0; k < 10; k++) begin
            d = (k < 5) ? {1'b1, 3'(k), 4'h0} : {6'h00, 2'(k - 5)};
            if (k == 9) begin
                d = 8'hdc; // reserved rate code with the unused bits set
            end
            bus(1, IDX_CLK, d, 0, 0);
            bus(0, IDX_CLK, 0, 8'hff, d & 8'hf3);
            cyc(500);
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            cyc(2500);
            expc = 16'(khz[k] * 2499 / 25000);
            chk("pll enable", {7'h0, d[7]}, {7'h0, pll});
            inr = (cnt + 16'd2 >= expc) && (cnt <= expc + 16'd2);
            chk("clock rate", 8'h01, {7'h0, inr});
        end
        $display("test clock rates done");
        bus(1, IDX_CLK, 8'h80, 0, 0);
        for (s = 0; s < 4; s++) begin
            for (c = 0; c < 5; c++) begin
                code = (c < 2) ? 0 : c - 1;
                wake = (c == 1) || (code == 2);
                cfg = (8'hff ^ (8'h03 << WU_LSB[s])) | (8'(code) << WU_LSB[s]);
                ien <= (c == 1) ? (8'h01 << IEN_BIT[s]) : ~(8'h01 << IEN_BIT[s]);
                bus(1, IDX_WU, cfg, 0, 0);
                clr <= 1'b1;
                @(posedge clk);
                seed = lfsr(seed);
                bus(1, IDX_PD, {5'h00, (seed[2:0] == 3'h0) ? 3'h1 : seed[2:0]}, 0, 0);
                cyc(3);
                clr <= 1'b0;
                cyc(20);
                chk("standby", 8'h01, {7'h0, stby});
                chk("clock in standby", 8'h00, cnt[7:0]);
                pulse_event(s);
                d = wake ? (8'h01 << s) : 8'h00;
                chk("standby after event", 8'(!wake), 8'(stby));
                chk("request flags", d, {4'h0, irqf});
                if (!wake) begin
                    bus(1, IDX_WU, 8'haa, 0, 0);
                    pulse_event(s);
                    chk("standby after rewake", 8'h00, {7'h0, stby});
                end
            end
        end
        $display("test wakeup done");
        bus(1, IDX_PD, 8'h08, 0, 0);
        cyc(2);
        chk("standby on zero write", 8'h00, {7'h0, stby});
        ones = 0;
        zeros = 0;
        for (k = 0; k < 300; k++) begin
            bus(0, IDX_PD, 0, 8'hf0, 8'h00);
            if (rdata[LF_BIT]) ones++;
            else zeros++;
        end
        chk("low clock toggles", 8'h01, {7'h0, ones > 0 && zeros > 0});
        $display("test low clock done");
        fw <= 1'b1;
        fe <= 1'b1;
        cyc(3);
        chk("flash go", 8'h03, {6'h0, fwgo, fego});
        pfail <= 1'b1;
        cyc(6);
        chk("flash go in power fail", 8'h00, {6'h0, fwgo, fego});
        pfail <= 1'b0;
        cyc(6);
        chk("flash go", 8'h03, {6'h0, fwgo, fego});
        fw <= 1'b0;
        fe <= 1'b0;
        $display("test flash guard done");
        bus(1, IDX_POWER_CONTROL, 8'h44, 0, 0);
        wdog <= 1'b1;
        @(posedge clk);
        wdog <= 1'b0;
        cyc(3);
        chk("watchdog reset", 8'h01, {7'h0, sysrst});
        wait_sysrst();
        bus(0, IDX_CAUSE, 0, 8'hff, 8'h01);
        bus(0, IDX_POWER_CONTROL, 0, 8'hff, 8'h00);
        bus(1, IDX_POWER_CONTROL, 8'h44, 0, 0);
        pin_n <= 1'b0;
        cyc(6);
        pin_n <= 1'b1;
        cyc(3);
        wait_sysrst();
        bus(0, IDX_CAUSE, 0, 8'hff, 8'h00);
        bus(0, IDX_POWER_CONTROL, 0, 8'hff, 8'h00);
        sgood <= 1'b0;
        cyc(60);
        chk("reset while supply low", 8'h01, {7'h0, sysrst});
        sgood <= 1'b1;
        cyc(4);
        wait_sysrst();
        bus(0, IDX_CAUSE, 0, 8'hff, 8'h00);
        $display("test reset sources done");
        final_report();
    end
endmodule : testbench
